// ### cordic_core.v
// cordic_core.v - unrolled combinational cordic, rotation and vectoring modes
// assumes angles in 32-bit turns (2^32 = one turn) and signed x/y with headroom for gain 1.647
`timescale 1ns/1ps
`default_nettype none

module cordic_core #(
  parameter ITER = 24
) (
  input wire vectoring, // 1: drive y to zero, 0: drive z to zero
  input wire [31:0] x_in, // start x
  input wire [31:0] y_in, // start y
  input wire [31:0] z_in, // start angle
  output wire [31:0] x_out, // final x
  output wire [31:0] y_out, // final y
  output wire [31:0] z_out // final angle
);

  ////////////////////////////////////////////////////////////////////////////
  function [31:0] step_angle;
    input integer i;
    begin
      case (i)
        0: step_angle = 32'h20000000;
        1: step_angle = 32'h12E4051D;
        2: step_angle = 32'h09FB385B;
        3: step_angle = 32'h051111D4;
        4: step_angle = 32'h028B0D43;
        5: step_angle = 32'h0145D7E1;
        6: step_angle = 32'h00A2F61E;
        7: step_angle = 32'h00517C55;
        8: step_angle = 32'h0028BE53;
        9: step_angle = 32'h00145F2E;
        10: step_angle = 32'h000A2F98;
        11: step_angle = 32'h000517CC;
        12: step_angle = 32'h00028BE6;
        13: step_angle = 32'h000145F3;
        14: step_angle = 32'h0000A2F9;
        15: step_angle = 32'h0000517C;
        16: step_angle = 32'h000028BE;
        17: step_angle = 32'h0000145F;
        18: step_angle = 32'h00000A2F;
        19: step_angle = 32'h00000517;
        20: step_angle = 32'h0000028B;
        21: step_angle = 32'h00000145;
        22: step_angle = 32'h000000A2;
        23: step_angle = 32'h00000051;
        default: step_angle = 32'h00000000;
      endcase
    end
  endfunction

  wire [31:0] xs [0:ITER];
  wire [31:0] ys [0:ITER];
  wire [31:0] zs [0:ITER];

  assign xs[0] = x_in;
  assign ys[0] = y_in;
  assign zs[0] = z_in;

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < ITER; g = g + 1) begin : stage
      wire ccw = vectoring ? ys[g][31] : ~zs[g][31];
      wire [31:0] xsh = $signed(xs[g]) >>> g;
      wire [31:0] ysh = $signed(ys[g]) >>> g;
      wire [31:0] ang = step_angle(g);
      assign xs[g+1] = ccw ? xs[g] - ysh : xs[g] + ysh;
      assign ys[g+1] = ccw ? ys[g] + xsh : ys[g] - xsh;
      assign zs[g+1] = ccw ? zs[g] - ang : zs[g] + ang;
    end
  endgenerate

  assign x_out = xs[ITER];
  assign y_out = ys[ITER];
  assign z_out = zs[ITER];

endmodule

`default_nettype wire

// ### host_model.sv
// host_model.sv - host pipeline issuing one operation at a time and taking the result
// assumes drives change at the falling edge and the unit samples at the rising edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire clk, // clock
  input wire issue_ready, // free
  input wire result_valid, // done
  input wire [31:0] result, // value
  output logic issue_valid, // offer
  output logic [3:0] issue_op, // code
  output logic [31:0] operand_b, // b
  output logic [31:0] operand_c, // c
  output logic result_read // consumed
);
  initial begin
    issue_valid = 1'b0;
    issue_op = 4'h0;
    operand_b = 32'h0;
    operand_c = 32'h0;
    result_read = 1'b0;
  end
  // lat counts falling edges from the take to result_valid; 20 means it never came
  task automatic run(input logic [3:0] op, input logic [31:0] b, input logic [31:0] c, input bit rd,
      output logic [31:0] res, output int lat);
    int n;
    @(negedge clk);
    issue_valid = 1'b1;
    issue_op = op;
    operand_b = b;
    operand_c = c;
    n = 0;
    // ready only moves on a rising edge, so it is settled here and the next rising edge takes the offer
    while (issue_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    lat = (issue_ready === 1'b1) ? 0 : 20;
    @(negedge clk);
    issue_valid = 1'b0;
    // released operands flip so a late sample is caught
    issue_op = ~op;
    operand_b = ~b;
    operand_c = ~c;
    while (result_valid !== 1'b1 && lat < 20) begin
      @(negedge clk);
      lat++;
    end
    res = result;
    if (rd) begin
      result_read = 1'b1;
      @(negedge clk);
      result_read = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### trig_math_unit.v
// trig_math_unit.v - single-precision trig/sqrt/divide unit beside a host cpu pipeline
// assumes the host issues one operation at a time on issue_valid/issue_ready and
// waits for result_valid before taking the result
//
// Behaviour
// RULE1 - operands and results are 32-bit single-precision floating point
// RULE2 - per-unit sine, cosine and arctangent, each done in 4 cycles
// RULE3 - two-argument per-unit arctangent quadrant operation done in 5 cycles
// RULE4 - multiply/divide by two pi fused before sine/cosine adds 2 cycles
// RULE5 - square root and division are single operations of 5 cycles
// RULE6 - inverse functions arcsine and arccosine computed directly in hardware
// RULE7 - host waits the latency; result holds until read or next issue
`timescale 1ns/1ps
`default_nettype none
`include "trig_math_unit_defines.vh"

module trig_math_unit #(
  parameter ITER = 24
) (
  input wire clk, // 10 MHz cpu clock
  input wire nrst, // asynchronous reset, active low
  input wire issue_valid, // host offers an operation
  output wire issue_ready, // unit can take an operation
  input wire [3:0] issue_op, // operation code
  input wire [31:0] operand_b, // first operand (float)
  input wire [31:0] operand_c, // second operand (float), divisor or x
  output reg result_valid, // result is ready and stable
  output reg [31:0] result, // float result
  input wire result_read // host has consumed the result
);

  ////////////////////////////////////////////////////////////////////////////
  function [23:0] fman;
    input [31:0] f;
    begin
      fman = (f[30:23] == 8'h00) ? 24'h000000 : {1'b1, f[22:0]};
    end
  endfunction

  // value = mag * 2^scale; truncating, subnormals flush to zero
  function [31:0] pack;
    input s;
    input [63:0] mag;
    input integer scale;
    integer p;
    integer i;
    integer e;
    reg [63:0] t;
    begin
      p = -1;
      for (i = 0; i < 64; i = i + 1) begin
        if (mag[i])
          p = i;
      end
      if (p < 23)
        t = mag << (23 - p);
      else
        t = mag >> (p - 23);
      e = p + scale + `EXP_BIAS;
      if (p < 0 || e <= 0)
        pack = 32'h00000000;
      else if (e >= 255)
        pack = {s, `FLOAT_INF};
      else
        pack = {s, e[7:0], t[22:0]};
    end
  endfunction

  // float times k (k in Q31) as a phase in turns, wrapped to 32 bits
  function [31:0] phase;
    input [31:0] f;
    input [31:0] k;
    reg [63:0] prod;
    reg [63:0] sh;
    integer s;
    begin
      prod = fman(f) * k;
      s = {24'h000000, f[30:23]};
      s = s - 149;
      if (s >= 32)
        sh = 64'h0;
      else if (s >= 0)
        sh = prod << s;
      else if (s > -64)
        sh = prod >> (-s);
      else
        sh = 64'h0;
      phase = f[31] ? -sh[31:0] : sh[31:0];
    end
  endfunction

  // float to signed Q28, aligned to exponent top
  function [31:0] fixq;
    input [31:0] f;
    input [7:0] top;
    reg [7:0] d;
    reg [31:0] m;
    begin
      d = top - f[30:23];
      m = (d > 8'h1E) ? 32'h00000000 : ({3'h0, fman(f), 5'h00} >> d);
      fixq = f[31] ? -m : m;
    end
  endfunction

  // digit-by-digit integer square root
  function [27:0] isqrt;
    input [55:0] v;
    integer i;
    reg [31:0] rem;
    reg [27:0] q;
    reg [29:0] trial;
    begin
      rem = 32'h0;
      q = 28'h0;
      for (i = 27; i >= 0; i = i - 1) begin
        rem = {rem[29:0], v[2*i+1 -: 2]};
        trial = {q, 2'b01};
        if (rem >= {2'b00, trial}) begin
          rem = rem - {2'b00, trial};
          q = {q[26:0], 1'b1};
        end else begin
          q = {q[26:0], 1'b0};
        end
      end
      isqrt = q;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // cordic setup
  reg vec;
  reg flip;
  reg [31:0] cx;
  reg [31:0] cy;
  reg [31:0] cz;
  reg [31:0] ph;
  reg [31:0] ax;
  reg [31:0] ay;
  reg [31:0] xsrc;
  reg [31:0] fb;
  reg [7:0] top;
  reg signed [63:0] sq;
  reg [29:0] omb;
  reg [31:0] root;
  wire [31:0] ox;
  wire [31:0] oy;
  wire [31:0] oz;

  always @* begin
    vec = 1'b0;
    flip = 1'b0;
    cx = `CORDIC_GAIN_Q30;
    cy = 32'h00000000;
    cz = 32'h00000000;
    ax = 32'h00000000;
    ay = 32'h00000000;
    // radian inputs are scaled to turns first, which costs the two extra cycles
    ph = phase(operand_b, (issue_op == `OP_SIN_RAD || issue_op == `OP_COS_RAD) ?
               `INV_2PI_Q31 : `ONE_Q31); // RULE4
    xsrc = (issue_op == `OP_ATAN_PU) ? `FLOAT_ONE : operand_c;
    top = (operand_b[30:23] > xsrc[30:23]) ? operand_b[30:23] : xsrc[30:23];
    fb = fixq(operand_b, 8'h7F);
    sq = $signed(fb) * $signed(fb);
    omb = `ONE_Q28 - sq[57:28];
    root = {3'h0, isqrt({omb, 26'h0000000}), 1'b0}; // RULE6
    case (issue_op)
      `OP_ATAN_PU, `OP_ATAN2_QUAD: begin
        vec = 1'b1;
        ay = fixq(operand_b, top); // RULE3
        ax = fixq(xsrc, top);
      end
      `OP_ASIN_PU: begin
        vec = 1'b1;
        ay = fb; // RULE6
        ax = root;
      end
      `OP_ACOS_PU: begin
        vec = 1'b1;
        ay = root; // RULE6
        ax = fb;
      end
      default: begin
        vec = 1'b0;
      end
    endcase
    if (vec) begin
      // cordic vectoring only converges for x >= 0, so left half-plane is mirrored
      if (ax[31]) begin
        cx = -ax; // RULE3
        cy = -ay;
        cz = `HALF_TURN;
      end else begin
        cx = ax;
        cy = ay;
      end
    end else begin
      flip = ph[31] ^ ph[30];
      cz = flip ? ph + `HALF_TURN : ph; // RULE2
    end
  end

  cordic_core #(
    .ITER(ITER)
  ) u_cordic (
    .vectoring(vec),
    .x_in(cx),
    .y_in(cy),
    .z_in(cz),
    .x_out(ox),
    .y_out(oy),
    .z_out(oz)
  );

  ////////////////////////////////////////////////////////////////////////////
  // result select and latency
  reg [31:0] res;
  reg [2:0] lat;
  reg [31:0] sinv;
  reg [31:0] cosv;
  reg [31:0] angv;
  reg [31:0] mag;
  reg [27:0] r;
  reg [48:0] q;
  integer ue;
  integer eb;
  integer ec;

  always @* begin
    res = `FLOAT_QNAN;
    lat = `LAT_BAD;
    mag = oy[31] ? -oy : oy;
    sinv = pack(flip ^ oy[31], {32'h0, mag}, -30); // RULE1
    mag = ox[31] ? -ox : ox;
    cosv = pack(flip ^ ox[31], {32'h0, mag}, -30);
    mag = oz[31] ? -oz : oz;
    angv = pack(oz[31], {32'h0, mag}, -32);
    eb = {24'h000000, operand_b[30:23]};
    ec = {24'h000000, operand_c[30:23]};
    ue = eb - `EXP_BIAS;
    r = isqrt(ue[0] ? {8'h00, fman(operand_b), 24'h000000} : {9'h000, fman(operand_b), 23'h000000});
    q = 49'h0;
    case (issue_op)
      `OP_SIN_PU: begin
        res = sinv;
        lat = `LAT_TRIG; // RULE2
      end
      `OP_COS_PU: begin
        res = cosv;
        lat = `LAT_TRIG; // RULE2
      end
      `OP_ATAN_PU: begin
        res = angv;
        lat = `LAT_TRIG; // RULE2
      end
      `OP_ATAN2_QUAD: begin
        res = angv;
        lat = `LAT_QUAD; // RULE3
      end
      `OP_SIN_RAD: begin
        res = sinv;
        lat = `LAT_FUSED; // RULE4
      end
      `OP_COS_RAD: begin
        res = cosv;
        lat = `LAT_FUSED; // RULE4
      end
      `OP_MPY2PI: begin
        res = pack(operand_b[31], {40'h0, fman(operand_b)} * {40'h0, `TWO_PI_MANT}, ue + `TWO_PI_EXP - 46);
        lat = `LAT_SCALE;
      end
      `OP_DIV2PI: begin
        res = pack(operand_b[31], {40'h0, fman(operand_b)} * {40'h0, `INV_2PI_MANT}, ue + `INV_2PI_EXP - 46);
        lat = `LAT_SCALE;
      end
      `OP_ASIN_PU, `OP_ACOS_PU: begin
        // outside [-1, 1] there is no real answer
        res = (operand_b[30:0] > `FLOAT_ONE) ? `FLOAT_QNAN : angv; // RULE6
        lat = `LAT_TRIG;
      end
      `OP_SQRT: begin
        lat = `LAT_ROOT_DIV; // RULE5
        if (operand_b[30:0] == 31'h0 || operand_b[30:23] == `EXP_ALL_ONES)
          res = operand_b[31] && operand_b[30:0] != 31'h0 ? `FLOAT_QNAN : operand_b;
        else if (operand_b[31])
          res = `FLOAT_QNAN;
        else
          res = pack(1'b0, {36'h0, r}, (ue - (ue & 1)) / 2 - 23); // RULE5
      end
      `OP_DIV: begin
        lat = `LAT_ROOT_DIV; // RULE5
        if (ec == 0)
          res = (eb == 0) ? `FLOAT_QNAN : {operand_b[31] ^ operand_c[31], `FLOAT_INF};
        else begin
          q = {fman(operand_b), 25'h0} / {25'h0, fman(operand_c)};
          res = pack(operand_b[31] ^ operand_c[31], {15'h0, q}, eb - ec - 25); // RULE5
        end
      end
      default: begin
        res = `FLOAT_QNAN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: one operation in flight, result published after its latency
  reg busy;
  reg [2:0] count;
  reg [31:0] pend;

  // a new issue waits until the previous result has been published
  assign issue_ready = ~busy; // RULE7

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      count <= 3'h0;
      pend <= 32'h00000000;
      result <= 32'h00000000;
      result_valid <= 1'b0;
    end else if (issue_valid && !busy) begin
      pend <= res;
      count <= lat - 3'h1;
      busy <= 1'b1;
      result_valid <= 1'b0; // RULE7
    end else if (busy) begin
      if (count == 3'h0) begin
        result <= pend; // RULE7
        result_valid <= 1'b1;
        busy <= 1'b0;
      end else begin
        count <= count - 3'h1;
      end
    end else if (result_read) begin
      result_valid <= 1'b0; // RULE7
    end
  end

endmodule

`default_nettype wire

// ### trig_math_unit_assertions.sv
// trig_math_unit_assertions.sv - latency and hand-over checks on the math unit ports
// assumes one clock domain, nrst asynchronous active low
`timescale 1ns/1ps
`default_nettype none
module trig_math_unit_checker (
  input wire clk, // clock
  input wire nrst, // reset
  input wire issue_valid, // offer
  input wire issue_ready, // free
  input wire [3:0] issue_op, // code
  input wire result_valid, // done
  input wire [31:0] result, // value
  input wire result_read // consumed
);
  wire take = issue_valid && issue_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  chk_trig_latency: assert property (take && issue_op <= 4'h2 |=> !result_valid [*4] ##1 result_valid)
    else $error("trig latency wrong");
  chk_quad_latency: assert property (take && issue_op == 4'h3 |=> !result_valid [*5] ##1 result_valid)
    else $error("quadrant latency wrong");
  chk_fused_latency: assert property (take && issue_op[3:1] == 3'h4 |=> !result_valid [*6] ##1 result_valid)
    else $error("fused latency wrong");
  chk_scale_latency: assert property (take && issue_op[3:1] == 3'h3 |=> !result_valid [*2] ##1 result_valid)
    else $error("scale latency wrong");
  chk_root_latency: assert property (take && issue_op[3:1] == 3'h2 |=> !result_valid [*5] ##1 result_valid)
    else $error("root or divide latency wrong");
  chk_inverse_latency: assert property (take && issue_op[3:1] == 3'h5 |=> !result_valid [*4] ##1 result_valid)
    else $error("inverse latency wrong");
  chk_result_hold: assert property (result_valid && !result_read && !take |=> result_valid && $stable(result))
    else $error("result not held");
  chk_busy_after_take: assert property (take |=> !issue_ready && !result_valid)
    else $error("ready after take");
  chk_read_clears: assert property (result_valid && result_read && !take |=> !result_valid)
    else $error("read did not clear");
endmodule
bind trig_math_unit trig_math_unit_checker u_checker (.clk(clk), .nrst(nrst), .issue_valid(issue_valid),
  .issue_ready(issue_ready), .issue_op(issue_op), .result_valid(result_valid), .result(result),
  .result_read(result_read));
`default_nettype wire

// ### trig_math_unit_bench.sv
// trig_math_unit_bench.sv - self-checking bench of the math unit
// assumes host_model drives the issue side; float results compared within at most 0x12C (300) ulps
`timescale 1ns/1ps
`default_nettype none
module trig_math_unit_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  wire issue_valid, issue_ready, result_valid, result_read;
  wire [3:0] issue_op;
  wire [31:0] operand_b, operand_c, result;
  int fails = 0;
  int n_compared = 0;
  always #50 clk = ~clk;
  trig_math_unit #(.ITER(24)) u_dut (.clk(clk), .nrst(nrst), .issue_valid(issue_valid),
    .issue_ready(issue_ready), .issue_op(issue_op), .operand_b(operand_b), .operand_c(operand_c),
    .result_valid(result_valid), .result(result), .result_read(result_read));
  host_model u_host (.clk(clk), .issue_ready(issue_ready), .result_valid(result_valid), .result(result),
    .issue_valid(issue_valid), .issue_op(issue_op), .operand_b(operand_b), .operand_c(operand_c),
    .result_read(result_read));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // truncating arithmetic: a bit-pattern distance stands in for a relative tolerance
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp, input logic [31:0] tol);
    logic [31:0] d;
    d = (seen > exp) ? seen - exp : exp - seen;
    n_compared++;
    if (^seen === 1'bx || d > tol) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic op_chk(input string what, input logic [3:0] op, input logic [31:0] b, input logic [31:0] c,
      input logic [31:0] exp, input int l, input logic [31:0] tol);
    logic [31:0] res;
    int lat;
    u_host.run(op, b, c, 1'b1, res, lat);
    check({what, " latency"}, 32'(lat), 32'(l), 32'h0);
    check(what, res, exp, tol);
    if (lat >= 20) results();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("ready at reset", {31'h0, issue_ready}, 32'h1, 32'h0);
    check("valid at reset", {31'h0, result_valid}, 32'h0, 32'h0);
    check("result at reset", result, 32'h0, 32'h0);
  endtask
  task automatic t_trig();
    op_chk("sin", 4'h0, 32'h3E800000, 32'h0, 32'h3F800000, 4, 32'h12C);
    op_chk("cos", 4'h1, 32'h3E000000, 32'h0, 32'h3F3504F3, 4, 32'h12C);
    op_chk("atan", 4'h2, 32'h3F800000, 32'h0, 32'h3E000000, 4, 32'h12C);
  endtask
  task automatic t_quad();
    op_chk("atan2 q2", 4'h3, 32'h3F800000, 32'hBF800000, 32'h3EC00000, 5, 32'h12C);
    op_chk("atan2 q3", 4'h3, 32'hBF800000, 32'hBF800000, 32'hBEC00000, 5, 32'h12C);
  endtask
  task automatic t_scale();
    op_chk("sin rad", 4'h8, 32'h3FC90FDB, 32'h0, 32'h3F800000, 6, 32'h12C);
    op_chk("cos rad", 4'h9, 32'h40490FDB, 32'h0, 32'hBF800000, 6, 32'h12C);
    op_chk("mpy2pi", 4'h6, 32'h3F800000, 32'h0, 32'h40C90FDB, 2, 32'h10);
    op_chk("div2pi", 4'h7, 32'h40C90FDB, 32'h0, 32'h3F800000, 2, 32'h10);
  endtask
  task automatic t_root_div();
    op_chk("sqrt", 4'h4, 32'h40800000, 32'h0, 32'h40000000, 5, 32'h10);
    op_chk("sqrt neg", 4'h4, 32'hBF800000, 32'h0, 32'h7FC00000, 5, 32'h0);
    op_chk("div", 4'h5, 32'h40C00000, 32'h40000000, 32'h40400000, 5, 32'h10);
  endtask
  task automatic t_inverse();
    op_chk("asin", 4'hA, 32'h3F000000, 32'h0, 32'h3DAAAAAB, 4, 32'h12C);
    op_chk("acos", 4'hB, 32'h3F000000, 32'h0, 32'h3E2AAAAB, 4, 32'h12C);
    op_chk("undefined op", 4'hC, 32'h3F800000, 32'h0, 32'h7FC00000, 1, 32'h0);
  endtask
  task automatic t_hold();
    logic [31:0] res;
    int lat;
    u_host.run(4'h4, 32'h41100000, 32'h0, 1'b0, res, lat);
    check("hold latency", 32'(lat), 32'h5, 32'h0);
    if (lat >= 20) results();
    repeat (3) @(negedge clk);
    check("held valid", {31'h0, result_valid}, 32'h1, 32'h0);
    check("held result", result, 32'h40400000, 32'h10);
    op_chk("after hold", 4'h4, 32'h41800000, 32'h0, 32'h40800000, 5, 32'h10);
    @(negedge clk);
    check("read clears", {31'h0, result_valid}, 32'h0, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk);
    t_reset();
    nrst = 1'b1;
    t_trig();
    t_quad();
    t_scale();
    t_root_div();
    t_inverse();
    t_hold();
    results();
  end
endmodule
`default_nettype wire

// ### trig_math_unit_defines.vh
// trig_math_unit_defines.vh - opcodes, latencies and numeric constants of the math unit
// assumes it is included by bare name from the trig_math_unit module only
`ifndef TRIG_MATH_UNIT_DEFINES_VH
`define TRIG_MATH_UNIT_DEFINES_VH

// operation codes on issue_op
`define OP_SIN_PU 4'h0
`define OP_COS_PU 4'h1
`define OP_ATAN_PU 4'h2
`define OP_ATAN2_QUAD 4'h3
`define OP_SQRT 4'h4
`define OP_DIV 4'h5
`define OP_MPY2PI 4'h6
`define OP_DIV2PI 4'h7
`define OP_SIN_RAD 4'h8
`define OP_COS_RAD 4'h9
`define OP_ASIN_PU 4'hA
`define OP_ACOS_PU 4'hB

// latencies in pipeline cycles
`define LAT_TRIG 3'h4
`define LAT_QUAD 3'h5
`define LAT_ROOT_DIV 3'h5
`define LAT_SCALE 3'h2
`define LAT_FUSED 3'h6
`define LAT_BAD 3'h1

// single-precision fields and special values
`define EXP_BIAS 127
`define EXP_ALL_ONES 8'hFF
`define FLOAT_ONE 32'h3F800000
`define FLOAT_QNAN 32'h7FC00000
`define FLOAT_INF 31'h7F800000

// fixed-point constants
`define CORDIC_GAIN_Q30 32'h26DD3B6A
`define HALF_TURN 32'h80000000
`define ONE_Q31 32'h80000000
`define INV_2PI_Q31 32'h145F306E
`define ONE_Q28 30'h10000000
`define TWO_PI_MANT 24'hC90FDB
`define TWO_PI_EXP 2
`define INV_2PI_MANT 24'hA2F983
`define INV_2PI_EXP (-3)

`endif
